// ---- logic/swlf_map.vh ----
`ifndef SWLF_MAP_VH
`define SWLF_MAP_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SWLF_OFF_STATUS 12'h000
`define SWLF_OFF_ACC 12'h004
`define SWLF_OFF_CTRL 12'h008
// ----------------------------------------
// Status word fields
// ----------------------------------------
`define SWLF_BIT_PARITY 0
`define SWLF_BIT_USER1 1
`define SWLF_BIT_OVF 2
`define SWLF_BIT_BANK_LO 3
`define SWLF_BIT_BANK_HI 4
`define SWLF_BANK_RESET 2'h0
`define SWLF_OVF_RESET 1'h0
`define SWLF_USER_RESET 1'h0
`define SWLF_ACC_RESET 8'h00
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define SWLF_OP_ADD 3'h0
`define SWLF_OP_ADD_CARRY 3'h1
`define SWLF_OP_SUB_BORROW 3'h2
`define SWLF_OP_MULTIPLY 3'h3
`define SWLF_OP_DIV 3'h4
`define SWLF_PRODUCT_LIMIT 16'h00FF
`define SWLF_BANK_BYTES 5'h08
`endif

// ---- logic/swlf_parity.v ----
`timescale 1ns/10ps
`default_nettype none
module swlf_parity
(
  input wire [7:0] acc,
  output wire odd
);
  // Odd count of ones reads as one
  assign odd = ^acc;
endmodule // swlf_parity
`default_nettype wire

// ---- logic/swlf_bank_addr.v ----
`timescale 1ns/10ps
`default_nettype none
module swlf_bank_addr
(
  input wire [1:0] bank,
  input wire [2:0] reg_index,
  output wire [7:0] data_addr
);
  // Bank n spans 8n..8n+7, bank 3 at 0x18-0x1F
  assign data_addr = {3'h0, bank, reg_index};
endmodule // swlf_bank_addr
`default_nettype wire

// ---- logic/swlf_status_word.v ----
`timescale 1ns/10ps
`default_nettype none
`include "swlf_map.vh"
module swlf_status_word
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire acc_we,
  input wire [7:0] acc_wdata,
  input wire op_done,
  input wire [2:0] op_code,
  input wire [15:0] op_result,
  input wire [7:0] op_divisor,
  input wire op_ovf,
  input wire [2:0] reg_index,
  output wire [7:0] reg_data_addr,
  output wire [1:0] register_bank_select,
  output wire overflow_flag,
  output wire parity_flag,
  output wire [7:0] program_status_word
);
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Shared by the write strobes and the read mux
  function is_status_addr;
    input [11:0] a;
    begin
      is_status_addr = (a == `SWLF_OFF_STATUS);
    end
  endfunction

  function is_acc_addr;
    input [11:0] a;
    begin
      is_acc_addr = (a == `SWLF_OFF_ACC);
    end
  endfunction

  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = is_status_addr(a) || is_acc_addr(a);
    end
  endfunction

  // ----------------------------------------
  // Operation decode
  // ----------------------------------------
  // Codes above divide are ignored, flag untouched
  function is_arith;
    input [2:0] c;
    begin
      case (c)
        `SWLF_OP_ADD: is_arith = 1'h1;
        `SWLF_OP_ADD_CARRY: is_arith = 1'h1;
        `SWLF_OP_SUB_BORROW: is_arith = 1'h1;
        `SWLF_OP_MULTIPLY: is_arith = 1'h1;
        `SWLF_OP_DIV: is_arith = 1'h1;
        default: is_arith = 1'h0;
      endcase
    end
  endfunction

  function ovf_of;
    input [2:0] c;
    input [15:0] product;
    input [7:0] divisor;
    input sum_ovf;
    begin
      case (c)
        `SWLF_OP_MULTIPLY: ovf_of = (product > `SWLF_PRODUCT_LIMIT);
        `SWLF_OP_DIV: ovf_of = (divisor == 8'h00);
        default: ovf_of = sum_ovf;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Unmapped reads return zero alongside the error
  function [31:0] read_word;
    input [11:0] a;
    input [7:0] status;
    input [7:0] acc;
    begin
      if (is_status_addr(a))
      begin
        read_word = {24'h000000, status};
      end
      else if (is_acc_addr(a))
      begin
        read_word = {24'h000000, acc};
      end
      else
      begin
        read_word = 32'h00000000;
      end
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [1:0] bank_sel_reg;
  reg [1:0] bank_sel_next;
  reg ovf_reg;
  reg ovf_next;
  reg user_flag_reg;
  reg user_flag_next;
  reg [7:0] acc_reg;
  reg [7:0] acc_next;
  wire setup_phase;
  wire access_phase;
  wire wr_go;
  wire status_wr;
  wire acc_wr;
  wire rd_setup;
  wire arith_done;
  wire ovf_calc;
  wire [7:0] status_word;

  // ----------------------------------------
  // Bus strobes
  // ----------------------------------------
  // Zero wait states; every access ends in one cycle
  assign pready = 1'h1;
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_go = access_phase & pwrite;
  assign status_wr = wr_go & is_status_addr(paddr);
  assign acc_wr = wr_go & is_acc_addr(paddr);
  assign rd_setup = setup_phase & ~pwrite;
  // Unmapped addresses answer with an error, no state change
  assign pslverr = access_phase & ~is_mapped(paddr);

  // ----------------------------------------
  // Datapath strobes
  // ----------------------------------------
  assign arith_done = op_done & is_arith(op_code);
  assign ovf_calc = ovf_of(op_code, op_result, op_divisor, op_ovf);

  // ----------------------------------------
  // Bank select
  // ----------------------------------------
  always @*
  begin
    bank_sel_next = bank_sel_reg;
    if (status_wr)
    begin
      bank_sel_next = {pwdata[`SWLF_BIT_BANK_HI], pwdata[`SWLF_BIT_BANK_LO]};
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bank_sel_reg <= `SWLF_BANK_RESET;
    end
    else
    begin
      bank_sel_reg <= bank_sel_next;
    end
  end

  // ----------------------------------------
  // Overflow flag
  // ----------------------------------------
  always @*
  begin
    ovf_next = ovf_reg;
    if (status_wr)
    begin
      ovf_next = pwdata[`SWLF_BIT_OVF];
    end
    // Datapath completes after the bus, so it wins a clash
    if (arith_done)
    begin
      ovf_next = ovf_calc;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_reg <= `SWLF_OVF_RESET;
    end
    else
    begin
      ovf_reg <= ovf_next;
    end
  end

  // ----------------------------------------
  // User flag
  // ----------------------------------------
  always @*
  begin
    user_flag_next = user_flag_reg;
    if (status_wr)
    begin
      user_flag_next = pwdata[`SWLF_BIT_USER1];
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      user_flag_reg <= `SWLF_USER_RESET;
    end
    else
    begin
      user_flag_reg <= user_flag_next;
    end
  end

  // ----------------------------------------
  // Accumulator mirror
  // ----------------------------------------
  // Held here so that parity and the ACC read have a source
  always @*
  begin
    acc_next = acc_reg;
    if (acc_wr)
    begin
      acc_next = pwdata[7:0];
    end
    // Datapath write wins over the bus
    if (acc_we)
    begin
      acc_next = acc_wdata;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg <= `SWLF_ACC_RESET;
    end
    else
    begin
      acc_reg <= acc_next;
    end
  end

  // ----------------------------------------
  // Parity and bank address
  // ----------------------------------------
  swlf_parity u_par
  (
    .acc(acc_reg),
    .odd(parity_flag)
  );

  swlf_bank_addr u_bank
  (
    .bank(register_bank_select),
    .reg_index(reg_index),
    .data_addr(reg_data_addr)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Loaded in setup so data is steady at the access edge
  // Limitation: a flag change during the access shows next read
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (rd_setup)
    begin
      prdata <= read_word(paddr, status_word, acc_reg);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Parity is rebuilt from the accumulator, never stored
  assign status_word = {3'h0, bank_sel_reg, ovf_reg, user_flag_reg, parity_flag};
  assign register_bank_select = bank_sel_reg;
  assign overflow_flag = ovf_reg;
  assign program_status_word = status_word;

endmodule // swlf_status_word
`default_nettype wire

// ---- testbench/swlf_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module swlf_props
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic acc_we,
  input wire logic [7:0] acc_wdata,
  input wire logic op_done,
  input wire logic [2:0] op_code,
  input wire logic [15:0] op_result,
  input wire logic [7:0] op_divisor,
  input wire logic op_ovf,
  input wire logic [2:0] reg_index,
  input wire logic [7:0] reg_data_addr,
  input wire logic [1:0] register_bank_select,
  input wire logic overflow_flag,
  input wire logic parity_flag,
  input wire logic [7:0] program_status_word
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_bank_addr: assert property (reg_data_addr == {3'h0, register_bank_select, reg_index})
    else $error("bank address");
  a_bank_bits: assert property (register_bank_select == program_status_word[4:3])
    else $error("bank bits");
  a_bank_write: assert property (psel && penable && pwrite && paddr == 12'h000 |=> register_bank_select == $past(pwdata[4:3]))
    else $error("bank write");
  a_product_ovf: assert property (op_done && op_code == 3'h3 |=> overflow_flag == ($past(op_result) > 16'h00FF))
    else $error("mul overflow");
  a_div_zero: assert property (op_done && op_code == 3'h4 |=> overflow_flag == ($past(op_divisor) == 8'h00))
    else $error("div overflow");
  a_add_ovf: assert property (op_done && op_code < 3'h3 |=> overflow_flag == $past(op_ovf))
    else $error("add overflow");
  a_acc_parity: assert property (acc_we |=> parity_flag == ^$past(acc_wdata))
    else $error("parity");
  a_parity_hold: assert property (!acc_we && !(psel && penable && pwrite && paddr == 12'h004) |=> $stable(parity_flag))
    else $error("parity hold");
  cover property (op_done && op_code == 3'h3 && op_result > 16'h00FF);
  cover property (op_done && op_code == 3'h4 && op_divisor == 8'h00);
  cover property (pslverr);
  cover property (register_bank_select == 2'h3);
endmodule // swlf_props
bind swlf_status_word swlf_props chk(.*);
`default_nettype wire

// ---- testbench/swlf_dp_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module swlf_dp_model
(
  input wire logic pclk,
  output logic acc_we,
  output logic op_done,
  output logic op_ovf,
  output logic [7:0] acc_wdata,
  output logic [7:0] op_divisor,
  output logic [2:0] op_code,
  output logic [15:0] op_result
);
  initial {acc_we, op_done, op_ovf, acc_wdata, op_divisor, op_code, op_result} = '0;
  task automatic op(input logic [2:0] c, input logic [15:0] r, input logic v);
    @(posedge pclk);
    {op_done, op_code, op_result, op_divisor, op_ovf} <= {1'h1, c, r, r[7:0], v};
    @(posedge pclk);
    op_done <= 1'h0;
  endtask
  task automatic acc(input logic [7:0] d);
    @(posedge pclk);
    {acc_we, acc_wdata} <= {1'h1, d};
    @(posedge pclk);
    acc_we <= 1'h0;
  endtask
endmodule // swlf_dp_model
`default_nettype wire

// ---- testbench/status_word_low_flags_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module status_word_low_flags_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic acc_we, op_done, op_ovf, overflow_flag, parity_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] acc_wdata, op_divisor, reg_data_addr, program_status_word;
  logic [2:0] op_code, reg_index;
  logic [15:0] op_result;
  logic [1:0] register_bank_select;
  int n_errors = 0, checked = 0;
  swlf_status_word uut(.*);
  swlf_dp_model dp(.*);
  initial
  begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic ov(input logic [2:0] c, input logic [15:0] r, input logic v, x);
    dp.op(c, r, v);
    @(posedge pclk);
    chk(overflow_flag, x);
  endtask
  task automatic t_par;
    dp.acc(8'h07);
    apb(1'h0, 12'h000, 0);
    chk(q, 32'h1);
    chk(program_status_word, 32'h1);
    apb(1'h1, 12'h004, 32'h3);
    chk(parity_flag, 0);
    apb(1'h0, 12'h004, 0);
    chk(q, 32'h3);
    apb(1'h0, 12'h008, 0);
    chk(e, 1);
    chk(q, 0);
    chk(pready, 1);
  endtask
  task automatic t_ovf;
    ov(3'h3, 16'h0100, 0, 1);
    ov(3'h3, 16'h00FF, 1, 0);
    ov(3'h4, 16'h0100, 0, 1);
    ov(3'h4, 16'h0003, 1, 0);
    ov(3'h0, 16'h0000, 1, 1);
    ov(3'h1, 16'h0000, 0, 0);
    ov(3'h2, 16'h0000, 1, 1);
    ov(3'h5, 16'h0000, 0, 1);
    ov(3'h2, 16'h0000, 0, 0);
  endtask
  task automatic t_bank;
    for (int b = 0; b < 4; b++)
    begin
      reg_index <= 3'h7;
      apb(1'h1, 12'h000, b << 3 | 32'hE1);
      apb(1'h0, 12'h000, 0);
      chk(q, b << 3);
      chk(program_status_word, b << 3);
      chk(reg_data_addr, b * 8 + 7);
    end
  endtask
  task automatic t_rst;
    dp.acc(8'h01);
    ov(3'h3, 16'h0100, 0, 1);
    presetn <= 1'h0;
    @(posedge pclk);
    chk({register_bank_select, overflow_flag, parity_flag, program_status_word}, 0);
    chk(prdata, 0);
    presetn <= 1'h1;
    @(posedge pclk);
    chk(program_status_word, 0);
    apb(1'h0, 12'h000, 0);
    chk(q, 0);
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #40000;
    n_errors++;
    final_report;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, reg_index} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_par;
    t_ovf;
    t_bank;
    t_rst;
    final_report;
  end
endmodule // status_word_low_flags_test
`default_nettype wire
